// File: hw/peripheral_event_router.sv
// event router: eight channels muxing peripheral events to users
// assumes sources synchronous to aclk except the async level inputs
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "peripheral_event_router_consts.svh"
module peripheral_event_router #(
   parameter int NCH = `PER_NCH,
   parameter int NSRC = `PER_NSRC,
   parameter int AW = 8
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // event sources
   input wire logic [NSRC-1:0] src_strobe,
   input wire logic [NSRC-1:0] src_data,
   input wire logic [NSRC-1:0] src_async,
   // channel outputs to users
   output peripheral_event_router_pkg::ev_s [NCH-1:0] chan_event,
   output logic [NCH-1:0] ch_async,
   output logic [NCH-1:0] ch_async_sync,
   output logic [NCH-1:0] presc_tick,
   // axi4-lite write
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   localparam int CW = $clog2(NCH);
   localparam int SW = `PER_SEL_W;
   localparam int PW = `PER_PSC_W;
   localparam int NW = `PER_CNT_W;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [NCH-1:0][SW-1:0] sel_q;
   logic [NCH-1:0][PW-1:0] psc_q;
   logic [NCH-1:0][NW-1:0] cnt_q;
   logic [NCH-1:0] sw_data_q, sw_stb_q, sw_go_q;
   logic [NCH-1:0] ext_stb, ext_dat, meta_q;
   logic [NSRC:0] stb_vec, dat_vec, asy_vec;
   logic [AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q, w_have_q, wr_do;
   logic [AW-1:0] wa, ra;
   logic [CW-1:0] wch, rch;

   // -------------------------------------------------------------
   // source select decode
   // -------------------------------------------------------------
   // unlisted codes, including absent peripherals, give no hit
   function automatic logic [4:0] sel_decode(input logic [SW-1:0] s);
      logic [4:0] r;
      r = '0;
      case (s)
         `SEL_RTC_OVERFLOW_SOURCE: r = {1'b1, `IDX_RTC_OVERFLOW_SOURCE};
         `SEL_RTC_COMPARE_SOURCE: r = {1'b1, `IDX_RTC_COMPARE_SOURCE};
         `SEL_CMP0: r = {1'b1, `IDX_CMP0};
         `SEL_CMP1: r = {1'b1, `IDX_CMP1};
         `SEL_CMP_WIN: r = {1'b1, `IDX_CMP_WIN};
         `SEL_ADC: r = {1'b1, `IDX_ADC};
         `SEL_PRESC: r = {1'b1, `IDX_PRESC};
         `SEL_LUT: r = {1'b1, `IDX_LUT};
         default: begin
            if (s >= `SEL_PIN0 && s <= `SEL_PIN7) begin
               r = {1'b1, 4'(`IDX_PIN0 + 4'(s - `SEL_PIN0))};
            end
         end
      endcase
      return r;
   endfunction : sel_decode

   // -------------------------------------------------------------
   // channel multiplexers
   // -------------------------------------------------------------
   // combinational on purpose: async path must not wait for a clock
   always_comb begin
      logic [4:0] hit;
      hit = '0;
      stb_vec = '0;
      dat_vec = '0;
      asy_vec = '0;
      ext_stb = '0;
      ext_dat = '0;
      ch_async = '0;
      for (int c = 0; c < NCH; c++) begin
         stb_vec = {presc_tick[c], src_strobe};
         dat_vec = {1'b0, src_data} & `SYNC_DATA_MASK;
         asy_vec = {1'b0, src_async} & `ASYNC_MASK;
         hit = sel_decode(sel_q[c]);
         if (hit[4]) begin
            ext_stb[c] = stb_vec[hit[3:0]];
            ext_dat[c] = dat_vec[hit[3:0]];
            ch_async[c] = asy_vec[hit[3:0]];
         end
      end
   end

   // routed strobe/data, software pair wins for its cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_event <= '0;
      end else if (ce) begin
         for (int c = 0; c < NCH; c++) begin
            if (sw_go_q[c]) begin
               chan_event[c].strobe <= sw_stb_q[c];
               chan_event[c].data <= sw_data_q[c];
            end else begin
               chan_event[c].strobe <= ext_stb[c];
               chan_event[c].data <= ext_dat[c];
            end
         end
      end
   end

   // second stage drives the output and the status read; first feeds nothing else
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         ch_async_sync <= '0;
      end else if (ce) begin
         meta_q <= ch_async;
         ch_async_sync <= meta_q;
      end
   end

   // -------------------------------------------------------------
   // per-channel prescaler
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         presc_tick <= '0;
      end else if (ce) begin
         for (int c = 0; c < NCH; c++) begin
            if (cnt_q[c] >= NW'((32'd1 << psc_q[c]) - 32'd1)) begin
               cnt_q[c] <= '0;
               presc_tick[c] <= 1'b1;
            end else begin
               cnt_q[c] <= cnt_q[c] + NW'(1);
               presc_tick[c] <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // axi4-lite write side
   // -------------------------------------------------------------
   assign wa = awaddr_q;
   assign wch = wa[`WORD_LSB +: CW];
   assign wr_do = aw_have_q && w_have_q && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            awaddr_q <= awaddr;
            aw_have_q <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            w_have_q <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_do) begin
            bvalid <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            if (wa[`WORD_LSB-1:0] == '0 && (wa < AW'(`REG_SW_DATA)
                || wa == AW'(`REG_SW_DATA) || wa == AW'(`REG_SW_STROBE)
                || wa == AW'(`REG_STATUS))) begin
               bresp <= `RESP_OKAY;
            end else begin
               bresp <= `RESP_SLVERR;
            end
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_q <= '0;
         psc_q <= '0;
         sw_data_q <= '0;
      end else if (ce && wr_do && wa[`WORD_LSB-1:0] == '0) begin
         if (wa < AW'(`REG_SW_DATA)) begin
            if (wstrb_q[0]) begin
               sel_q[wch] <= wdata_q[`FLD_SEL_LSB +: SW];
            end
            if (wstrb_q[1]) begin
               psc_q[wch] <= wdata_q[`FLD_PSC_LSB +: PW];
            end
         end else if (wa == AW'(`REG_SW_DATA) && wstrb_q[0]) begin
            sw_data_q <= wdata_q[NCH-1:0];
         end
      end
   end

   // software event: strobe write fires, at once, every channel named in it or set in sw_data_q
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_go_q <= '0;
         sw_stb_q <= '0;
      end else if (ce) begin
         if (wr_do && wa == AW'(`REG_SW_STROBE) && wstrb_q[0]) begin
            sw_stb_q <= wdata_q[NCH-1:0];
            sw_go_q <= wdata_q[NCH-1:0] | sw_data_q;
         end else begin
            sw_go_q <= '0;
            sw_stb_q <= '0;
         end
      end
   end

   // -------------------------------------------------------------
   // axi4-lite read side
   // -------------------------------------------------------------
   assign ra = araddr;
   assign rch = ra[`WORD_LSB +: CW];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= '0;
            rresp <= `RESP_OKAY;
            if (ra[`WORD_LSB-1:0] != '0) begin
               rresp <= `RESP_SLVERR;
            end else if (ra < AW'(`REG_SW_DATA)) begin
               rdata[`FLD_SEL_LSB +: SW] <= sel_q[rch];
               rdata[`FLD_PSC_LSB +: PW] <= psc_q[rch];
            end else if (ra == AW'(`REG_SW_DATA)) begin
               rdata[NCH-1:0] <= sw_data_q;
            end else if (ra == AW'(`REG_STATUS)) begin
               for (int c = 0; c < NCH; c++) begin
                  rdata[c] <= chan_event[c].strobe;
                  rdata[NCH + c] <= ch_async_sync[c];
               end
            end else if (ra != AW'(`REG_SW_STROBE)) begin
               rresp <= `RESP_SLVERR;
            end
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_pin0_on;
      ce && sel_q[0] == `SEL_PIN0 && !sw_go_q[0];
   endsequence
   sequence s_async_hold;
      ce && sel_q[0] == `SEL_PIN0 && src_async[`IDX_PIN0];
   endsequence

   property p_sync_latency;
      s_pin0_on and src_strobe[`IDX_PIN0] |=> chan_event[0].strobe;
   endproperty
   a_sync_latency: assert property (p_sync_latency)
      else $error("routed strobe missed its cycle");

   property p_async_direct;
      sel_q[0] == `SEL_PIN0 |-> ch_async[0] == src_async[`IDX_PIN0];
   endproperty
   a_async_direct: assert property (p_async_direct)
      else $error("async level delayed or wrong");

   property p_async_sync;
      s_async_hold ##1 s_async_hold |=> ch_async_sync[0];
   endproperty
   a_async_sync: assert property (p_async_sync)
      else $error("synchronised async late");

   property p_sw_override;
      ce && sw_go_q[0] |=> chan_event[0] == {$past(sw_stb_q[0]),
                                             $past(sw_data_q[0])};
   endproperty
   a_sw_override: assert property (p_sw_override)
      else $error("software event not on channel");

   property p_sw_once;
      sw_go_q != '0 && ce |=> sw_go_q == '0;
   endproperty
   a_sw_once: assert property (p_sw_once)
      else $error("software event longer than one cycle");

   property p_zero_sel;
      ce && sel_q[0] == `SEL_NONE && !sw_go_q[0] |=> chan_event[0] == '0;
   endproperty
   a_zero_sel: assert property (p_zero_sel)
      else $error("select zero routed an event");

   property p_no_data_adc;
      ce && sel_q[1] == `SEL_ADC && !sw_go_q[1]
         |=> !chan_event[1].data && !$past(ch_async[1]);
   endproperty
   a_no_data_adc: assert property (p_no_data_adc)
      else $error("strobe-only source gave data");

   property p_presc_wrap;
      ce && cnt_q[0] == NW'((32'd1 << psc_q[0]) - 32'd1)
         |=> presc_tick[0] && cnt_q[0] == '0;
   endproperty
   a_presc_wrap: assert property (p_presc_wrap)
      else $error("prescaler tick wrong");

   property p_bad_read;
      ce && arvalid && arready && ra[`WORD_LSB-1:0] != '0
         |=> rvalid && rresp == `RESP_SLVERR;
   endproperty
   a_bad_read: assert property (p_bad_read)
      else $error("unaligned read not refused");

endmodule : peripheral_event_router

// File: inc/peripheral_event_router_consts.svh
// named constants of the event router: sizes, select codes, map
// assumes inclusion by the router package and the router module
`ifndef PERIPHERAL_EVENT_ROUTER_CONSTS_SVH
`define PERIPHERAL_EVENT_ROUTER_CONSTS_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PER_NCH 8
`define PER_NSRC 15
`define PER_SEL_W 8
`define PER_PSC_W 4
`define PER_CNT_W 15
// ----------------------------------------------------------------
// source select codes, zero routes nothing
// ----------------------------------------------------------------
`define SEL_NONE 8'h00
`define SEL_RTC_OVERFLOW_SOURCE 8'h08
`define SEL_RTC_COMPARE_SOURCE 8'h09
`define SEL_CMP0 8'h10
`define SEL_CMP1 8'h11
`define SEL_CMP_WIN 8'h12
`define SEL_ADC 8'h20
`define SEL_PIN0 8'h50
`define SEL_PIN7 8'h57
`define SEL_PRESC 8'h80
`define SEL_LUT 8'hb0
// ----------------------------------------------------------------
// source indices and capability masks
// ----------------------------------------------------------------
`define IDX_RTC_OVERFLOW_SOURCE 4'h0
`define IDX_RTC_COMPARE_SOURCE 4'h1
`define IDX_CMP0 4'h2
`define IDX_CMP1 4'h3
`define IDX_CMP_WIN 4'h4
`define IDX_ADC 4'h5
`define IDX_PIN0 4'h6
`define IDX_LUT 4'he
`define IDX_PRESC 4'hf
`define ASYNC_MASK 16'h7fcf
`define SYNC_DATA_MASK 16'h7fc0
// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define REG_CHAN_BASE 8'h00
`define REG_SW_DATA 8'h20
`define REG_SW_STROBE 8'h24
`define REG_STATUS 8'h28
`define WORD_LSB 2
`define FLD_SEL_LSB 0
`define FLD_PSC_LSB 8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: inc/peripheral_event_router_pkg.sv
// types shared by the event router and its bench
// assumes the constants header sits beside it
`include "peripheral_event_router_consts.svh"
package peripheral_event_router_pkg;
   // one channel event: {strobe, data} is also the data event code
   typedef struct packed {
      logic strobe;
      logic data;
   } ev_s;
   typedef logic [`PER_SEL_W-1:0] sel_t;
endpackage : peripheral_event_router_pkg

// File: tb/event_peers.sv
// partner model: the generating peripherals beside the event router
// assumes one clock, aclk; sources change just after its rising edge
`timescale 1ns/1ps
module event_peers (
   // clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   // generated events
   output logic [14:0] src_strobe,
   output logic [14:0] src_data,
   output logic [14:0] src_async
);
   // ---------------------------------------------------------------
   // generators
   // ---------------------------------------------------------------
   // a stopped peer drives nothing, so stale events cannot leak
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         src_strobe <= '0;
         src_data <= '0;
         src_async <= '0;
      end else begin
         // never two strobe cycles in a row: single-cycle events
         src_strobe <= 15'($urandom) & ~src_strobe;
         src_data <= 15'($urandom);
         src_async <= 15'($urandom);
      end
   end
endmodule : event_peers

// File: tb/peripheral_event_router_tb_top.sv
// self-checking bench of the event router with random peers
// assumes the router package and constants header are compiled first
`timescale 1ns/1ps
`include "peripheral_event_router_consts.svh"
module peripheral_event_router_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic run = 1'b0;
   logic [14:0] src_strobe, src_data, src_async;
   peripheral_event_router_pkg::ev_s [7:0] chan_event;
   logic [7:0] ch_async, ch_async_sync, presc_tick;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = '0, rdata, seed_v, v;
   logic [1:0] bresp, rresp;
   logic [7:0] sel_m [8];
   logic [3:0] psc_m [8];
   logic [1:0] exp_ev [8];
   int tick_n [8];
   logic [7:0] as1 = '0, as2 = '0, pa, sw_st, sw_d;
   logic sw_arm = 0, bv_prev = 0, cnt_on = 0, bv_rise = 0;
   logic ce_i = 1'b1, cfg_arm = 1'b0;
   logic [7:0] cfg_sel = '0;
   int errors = 0, n_tests = 0, i, win, cfg_ch = 0;
   logic [7:0] codes [13] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h10, 8'h11,
                              8'h12, 8'h20, 8'h50, 8'h53, 8'h57, 8'hb0,
                              8'h80};

   always #2.5 aclk = ~aclk;

   event_peers i_peers (.aclk(aclk), .aresetn(aresetn), .run(run),
      .src_strobe(src_strobe), .src_data(src_data), .src_async(src_async));

   peripheral_event_router i_dut (.aclk(aclk), .aresetn(aresetn),
      .ce(ce_i), .src_strobe(src_strobe), .src_data(src_data),
      .src_async(src_async), .chan_event(chan_event), .ch_async(ch_async),
      .ch_async_sync(ch_async_sync), .presc_tick(presc_tick),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   // ---------------------------------------------------------------
   // checking helpers
   // ---------------------------------------------------------------
   function automatic int src_of(input logic [7:0] s);
      case (s)
         8'h08: return 0;
         8'h09: return 1;
         8'h10: return 2;
         8'h11: return 3;
         8'h12: return 4;
         8'h20: return 5;
         8'hb0: return 14;
         8'h80: return 15;
         default: return (s >= 8'h50 && s <= 8'h57) ? 6 + int'(s[2:0]) : -1;
      endcase
   endfunction : src_of

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] s);
      n_tests++;
      if (e !== s) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   task automatic end_sim();
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) done = 1;
      end
      bready <= 1'b0;
      if (!done) begin
         errors++;
         end_sim();
      end else begin
         chk("bresp", 32'(er), 32'(bresp));
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) done = 1;
      end
      rready <= 1'b0;
      if (!done) begin
         errors++;
         end_sim();
      end else begin
         chk("rresp", 32'(er), 32'(rresp));
         if (er == `RESP_OKAY) chk("rdata", ed, rdata);
      end
   endtask : rd

   // ---------------------------------------------------------------
   // cycle monitor: predicts every channel one cycle ahead
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      #1;
      if (aresetn) begin
         // writes land at the edge where bvalid rises
         bv_rise = bvalid && !bv_prev;
         bv_prev = bvalid;
         if (cfg_arm && bv_rise) begin
            sel_m[cfg_ch] = cfg_sel;
            cfg_arm = 1'b0;
         end
         chk("ch_async_sync", 32'(as2), 32'(ch_async_sync));
         if (ce_i) as2 = as1;
         pa = '0;
         for (int c = 0; c < 8; c++) begin
            i = src_of(sel_m[c]);
            chk("chan_event", 32'(exp_ev[c]), 32'(chan_event[c]));
            // a frozen router keeps its last event
            if (ce_i) begin
               exp_ev[c] = 2'b00;
               if (i == 15) begin
                  exp_ev[c] = {presc_tick[c], 1'b0};
               end else if (i >= 0) begin
                  exp_ev[c] = {src_strobe[i], src_data[i] & (i > 5)};
               end
            end
            if (i >= 0 && i < 15 && i != 4 && i != 5) pa[c] = src_async[i];
            if (cnt_on) tick_n[c] += int'(presc_tick[c]);
         end
         chk("ch_async", 32'(pa), 32'(ch_async));
         if (ce_i) as1 = pa;
         // software event wins over routed sources for one cycle
         if (sw_arm && bv_rise) begin
            for (int c = 0; c < 8; c++) begin
               if (sw_st[c] || sw_d[c]) begin
                  exp_ev[c] = {sw_st[c], sw_d[c]};
               end
            end
            sw_arm = 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      seed_v = $urandom(32'h0000_025b);
      for (int c = 0; c < 8; c++) begin
         sel_m[c] = '0;
         psc_m[c] = '0;
         exp_ev[c] = '0;
      end
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int c = 0; c < 8; c++) rd(8'(4 * c), '0, `RESP_OKAY);
      rd(`REG_SW_STROBE, '0, `RESP_OKAY);
      rd(8'h30, '0, `RESP_SLVERR);
      wr(8'h05, 32'h0000_0050, `RESP_SLVERR);
      for (int r = 0; r < 5; r++) begin
         // peers idle while routing changes, so no mixed cycles
         run <= 1'b0;
         repeat (3) @(posedge aclk);
         for (int c = 0; c < 8; c++) begin
            cfg_sel = (r == 0) ? 8'h00 : codes[$urandom % 13];
            // fixed picks so pin and strobe-only checks see traffic
            if (c == 0 && r == 1) cfg_sel = 8'h50;
            if (c == 0 && r == 2) cfg_sel = 8'h20;
            if (c == 1) cfg_sel = sel_m[0];
            psc_m[c] = (r == 4 && c == 7) ? 4'hf : 4'($urandom % 6);
            cfg_ch = c;
            cfg_arm = 1'b1;
            wr(8'(4 * c), {20'h0_0000, psc_m[c], cfg_sel},
               `RESP_OKAY);
         end
         rd(8'(4 * r), {20'h0_0000, psc_m[r], sel_m[r]}, `RESP_OKAY);
         win = (r == 4) ? 65536 : 64;
         run <= 1'b1;
         @(posedge aclk);
         for (int c = 0; c < 8; c++) tick_n[c] = 0;
         cnt_on = 1'b1;
         repeat (win) @(posedge aclk);
         cnt_on = 1'b0;
         for (int c = 0; c < 8; c++) begin
            chk("presc_tick", 32'(win >> psc_m[c]), 32'(tick_n[c]));
         end
         v = $urandom;
         sw_d = v[7:0];
         sw_st = v[15:8];
         wr(`REG_SW_DATA, {24'h00_0000, sw_d}, `RESP_OKAY);
         rd(`REG_SW_DATA, {24'h00_0000, sw_d}, `RESP_OKAY);
         sw_arm = 1'b1;
         wr(`REG_SW_STROBE, {24'h00_0000, sw_st}, `RESP_OKAY);
         // clock enable low: all state holds, async path still passes
         ce_i <= 1'b0;
         repeat (2) @(posedge aclk);
         ce_i <= 1'b1;
         @(posedge aclk);
      end
      end_sim();
   end
endmodule : peripheral_event_router_tb_top
